//--- logic/spu_rx_consts.vh
`ifndef SPU_RX_CONSTS_VH
`define SPU_RX_CONSTS_VH

// Register byte offsets
`define SPU_OFS_CTRL     5'h00
`define SPU_OFS_BAUD_LO  5'h04
`define SPU_OFS_BAUD_HI  5'h08
`define SPU_OFS_RX_STAT  5'h0C
`define SPU_OFS_RX_DATA  5'h10
`define SPU_OFS_INT_ST   5'h14
`define SPU_OFS_INT_EN   5'h18
`define SPU_OFS_INT_CLR  5'h1C

// Control field positions
`define SPU_CTL_PEN      0
`define SPU_CTL_SYNC     1
`define SPU_CTL_CONTINUOUS_RECEIVE_ENABLE     2
`define SPU_CTL_RX9      3
`define SPU_CTL_ADDRESS_DETECT_ENABLE    4
`define SPU_CTL_HSPD     5
`define SPU_CTL_WIDE     6
`define SPU_CTL_W        7

// Receive status field positions
`define SPU_ST_BIT9      0
`define SPU_ST_FERR      1
`define SPU_ST_OVR       2
`define SPU_ST_RFLAG     3

// Interrupt event bits
`define SPU_EV_RX        0
`define SPU_EV_OVR       1
`define SPU_EV_FERR      2
`define SPU_EV_W         3

// Reset values
`define SPU_CTRL_RST     7'h00
`define SPU_BAUD_RST     8'h00
`define SPU_EV_RST       3'h0

// Generator ticks per bit time
`define SPU_TPB_SLOW     7'h40
`define SPU_TPB_MID      7'h10
`define SPU_TPB_FAST     7'h04

`endif

//--- logic/spu_rx.v
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`include "spu_rx_consts.vh"

module spu_rx #(
    parameter ADDR_W = 5,
    parameter DATA_W = 32
) (
    // Clock and reset
    input  wire              i_mclk,
    input  wire              i_rst_n,
    // Avalon-MM slave
    input  wire [ADDR_W-1:0] i_address,
    input  wire              i_read,
    input  wire              i_write,
    input  wire [DATA_W-1:0] i_writedata,
    output wire [DATA_W-1:0] o_readdata,
    output wire              o_waitrequest,
    // Serial line and interrupt
    input  wire              i_rxd,
    output wire              o_irq
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA  = 2'h2;
    localparam ST_STOP  = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Ticks of the generator per bit time
    function [6:0] tpb;
        input hspd;
        input wide;
        begin
            case ({wide, hspd})
                2'b00:   tpb = `SPU_TPB_SLOW;
                2'b11:   tpb = `SPU_TPB_FAST;
                default: tpb = `SPU_TPB_MID;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    reg  [`SPU_CTL_W-1:0] ctrl_ff;
    reg  [7:0]            baud_lo_ff;
    reg  [7:0]            baud_hi_ff;
    reg  [`SPU_EV_W-1:0]  int_en_ff;
    reg  [`SPU_EV_W-1:0]  int_st_ff;
    reg                   wait_ff;
    reg  [DATA_W-1:0]     rdata_ff;
    reg                   irq_ff;
    reg  [15:0]           brg_cnt_ff;
    reg  [1:0]            st_ff;
    reg  [6:0]            tcnt_ff;
    reg  [3:0]            bit_idx_ff;
    reg  [8:0]            shift_ff;
    reg                   rxd_prev_ff;
    reg                   ovr_ff;
    reg  [9:0]            buf_ff [0:1];
    reg                   wr_ptr_ff;
    reg                   rd_ptr_ff;
    reg  [1:0]            cnt_ff;
    reg  [DATA_W-1:0]     nxt_rdata;

    wire                  pen   = ctrl_ff[`SPU_CTL_PEN];
    wire                  continuous_receive_enable  = ctrl_ff[`SPU_CTL_CONTINUOUS_RECEIVE_ENABLE];
    wire                  rx9   = ctrl_ff[`SPU_CTL_RX9];
    wire                  address_detect_enable = ctrl_ff[`SPU_CTL_ADDRESS_DETECT_ENABLE];
    wire                  hspd  = ctrl_ff[`SPU_CTL_HSPD];
    wire                  wide  = ctrl_ff[`SPU_CTL_WIDE];

    // Receiver runs only in asynchronous mode with port and receive on
    wire                  rx_on = pen & ~ctrl_ff[`SPU_CTL_SYNC] & continuous_receive_enable;

    // Bus handshake: request taken while waitrequest high, done when low
    wire                  req   = i_read | i_write;
    wire                  done  = ~wait_ff & req;
    wire                  wr_en = done & i_write;
    wire                  rd_en = done & i_read;

    ////////////////////////////////////////////////////////////////////////
    // Baud tick generator
    wire [15:0]           div   = wide ? {baud_hi_ff, baud_lo_ff} : {8'h00, baud_lo_ff};
    wire                  tick  = (brg_cnt_ff == div);
    wire [6:0]            kpb   = tpb(hspd, wide);
    wire [6:0]            half  = {1'b0, kpb[6:1]};
    wire                  start_det = (st_ff == ST_IDLE) & rx_on & rxd_prev_ff & ~i_rxd;
    wire                  mid_smp  = tick & (tcnt_ff == half - 7'h01);
    wire                  bit_smp  = tick & (tcnt_ff == kpb - 7'h01);
    wire [3:0]            last_bit = rx9 ? 4'h8 : 4'h7;

    // Restart phase at each start edge so sampling lands mid-bit
    always @(posedge i_mclk) begin
        if (!i_rst_n || !rx_on || start_det || tick) begin
            brg_cnt_ff <= 16'h0000;
        end else begin
            brg_cnt_ff <= brg_cnt_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Character assembly and buffer decisions
    wire                  stop_smp = (st_ff == ST_STOP) & bit_smp;
    wire [7:0]            rx_byte  = rx9 ? shift_ff[7:0] : shift_ff[8:1];
    wire                  rx_bit9  = rx9 & shift_ff[8];
    wire                  ferr     = ~i_rxd;
    wire                  addr_ok  = ~(rx9 & address_detect_enable & ~rx_bit9);
    wire                  pop      = rd_en & (i_address == `SPU_OFS_RX_DATA) &
                                     (cnt_ff != 2'h0);
    wire                  full     = (cnt_ff == 2'h2);
    wire                  push     = stop_smp & addr_ok & ~ovr_ff & (~full | pop);
    wire                  ovr_set  = stop_smp & addr_ok & ~ovr_ff & full & ~pop;
    wire [9:0]            head     = buf_ff[rd_ptr_ff];

    // Receive state machine
    always @(posedge i_mclk) begin
        if (!i_rst_n || !rx_on) begin
            st_ff      <= ST_IDLE;
            tcnt_ff    <= 7'h00;
            bit_idx_ff <= 4'h0;
            shift_ff   <= 9'h000;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    tcnt_ff <= 7'h00;
                    if (start_det) begin
                        st_ff <= ST_START;
                    end
                end
                ST_START: begin
                    if (mid_smp) begin
                        tcnt_ff    <= 7'h00;
                        bit_idx_ff <= 4'h0;
                        st_ff      <= i_rxd ? ST_IDLE : ST_DATA;
                    end else if (tick) begin
                        tcnt_ff <= tcnt_ff + 7'h01;
                    end
                end
                ST_DATA: begin
                    if (bit_smp) begin
                        tcnt_ff    <= 7'h00;
                        shift_ff   <= {i_rxd, shift_ff[8:1]};
                        bit_idx_ff <= bit_idx_ff + 4'h1;
                        if (bit_idx_ff == last_bit) begin
                            st_ff <= ST_STOP;
                        end
                    end else if (tick) begin
                        tcnt_ff <= tcnt_ff + 7'h01;
                    end
                end
                ST_STOP: begin
                    if (bit_smp) begin
                        tcnt_ff <= 7'h00;
                        st_ff   <= ST_IDLE;
                    end else if (tick) begin
                        tcnt_ff <= tcnt_ff + 7'h01;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Line history for start edge detection
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rxd_prev_ff <= 1'b1;
        end else begin
            rxd_prev_ff <= i_rxd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-character receive buffer
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_buf
            always @(posedge i_mclk) begin
                if (!i_rst_n) begin
                    buf_ff[gi] <= 10'h000;
                end else if (push && (wr_ptr_ff == gi)) begin
                    buf_ff[gi] <= {ferr, rx_bit9, rx_byte};
                end
            end
        end
    endgenerate

    // Pointers and occupancy
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            case ({push, pop})
                2'b10:   cnt_ff <= cnt_ff + 2'h1;
                2'b01:   cnt_ff <= cnt_ff - 2'h1;
                default: cnt_ff <= cnt_ff;
            endcase
        end
    end

    // Overrun flag, held until reception is switched off
    always @(posedge i_mclk) begin
        if (!i_rst_n || !continuous_receive_enable) begin
            ovr_ff <= 1'b0;
        end else if (ovr_set) begin
            ovr_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events, set wins over clear
    wire [`SPU_EV_W-1:0]  ev_set = {push & ferr, ovr_set, push};
    wire [`SPU_EV_W-1:0]  ev_clr = (wr_en && (i_address == `SPU_OFS_INT_CLR)) ?
                                   i_writedata[`SPU_EV_W-1:0] : `SPU_EV_RST;

    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            int_st_ff <= `SPU_EV_RST;
            irq_ff    <= 1'b0;
        end else begin
            int_st_ff <= (int_st_ff & ~ev_clr) | ev_set;
            irq_ff    <= |(int_st_ff & int_en_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ctrl_ff    <= `SPU_CTRL_RST;
            baud_lo_ff <= `SPU_BAUD_RST;
            baud_hi_ff <= `SPU_BAUD_RST;
            int_en_ff  <= `SPU_EV_RST;
        end else if (wr_en) begin
            case (i_address)
                `SPU_OFS_CTRL:    ctrl_ff    <= i_writedata[`SPU_CTL_W-1:0];
                `SPU_OFS_BAUD_LO: baud_lo_ff <= i_writedata[7:0];
                `SPU_OFS_BAUD_HI: baud_hi_ff <= i_writedata[7:0];
                `SPU_OFS_INT_EN:  int_en_ff  <= i_writedata[`SPU_EV_W-1:0];
                default:          int_en_ff  <= int_en_ff;
            endcase
        end
    end

    // Read mux
    always @* begin
        nxt_rdata = {DATA_W{1'b0}};
        case (i_address)
            `SPU_OFS_CTRL:    nxt_rdata[`SPU_CTL_W-1:0] = ctrl_ff;
            `SPU_OFS_BAUD_LO: nxt_rdata[7:0] = baud_lo_ff;
            `SPU_OFS_BAUD_HI: nxt_rdata[7:0] = baud_hi_ff;
            `SPU_OFS_RX_STAT: begin
                nxt_rdata[`SPU_ST_BIT9]  = rx9 & (head[8] | address_detect_enable);
                nxt_rdata[`SPU_ST_FERR]  = head[9] & (cnt_ff != 2'h0);
                nxt_rdata[`SPU_ST_OVR]   = ovr_ff;
                nxt_rdata[`SPU_ST_RFLAG] = (cnt_ff != 2'h0);
            end
            `SPU_OFS_RX_DATA: nxt_rdata[7:0] = head[7:0];
            `SPU_OFS_INT_ST:  nxt_rdata[`SPU_EV_W-1:0] = int_st_ff;
            `SPU_OFS_INT_EN:  nxt_rdata[`SPU_EV_W-1:0] = int_en_ff;
            default:          nxt_rdata = {DATA_W{1'b0}};
        endcase
    end

    // Handshake: one wait cycle, data captured when the request is taken
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wait_ff  <= 1'b1;
            rdata_ff <= {DATA_W{1'b0}};
        end else begin
            if (!wait_ff) begin
                wait_ff <= 1'b1;
            end else if (req) begin
                wait_ff <= 1'b0;
            end
            if (wait_ff && i_read) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_readdata    = rdata_ff;
    assign o_waitrequest = wait_ff;
    assign o_irq         = irq_ff;

endmodule // spu_rx

//--- sim/spu_rx_properties.sv
`timescale 1ns/1ns
`include "spu_rx_consts.vh"
module spu_rx_properties (
    // Clock and reset
    input wire        i_mclk,
    input wire        i_rst_n,
    // Register bus
    input wire [4:0]  i_address,
    input wire        i_read,
    input wire        i_write,
    input wire [31:0] i_writedata,
    input wire [31:0] o_readdata,
    input wire        o_waitrequest,
    // Line and interrupt
    input wire        i_rxd,
    input wire        o_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    reg  [6:0] ctrl_ff;
    reg  [2:0] en_ff;
    reg  [2:0] off_ff;
    wire       wr_done = i_write && !o_waitrequest;
    wire       st_rd   = i_read && !o_waitrequest && i_address == `SPU_OFS_RX_STAT;
    ////////////////////////////////////////////////////////////////////////////
    // Shadows of control and enable, and cycles spent with reception off
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ctrl_ff <= `SPU_CTRL_RST;
            en_ff   <= `SPU_EV_RST;
            off_ff  <= 3'h0;
        end else begin
            if (wr_done && i_address == `SPU_OFS_CTRL)
                ctrl_ff <= i_writedata[6:0];
            if (wr_done && i_address == `SPU_OFS_INT_EN)
                en_ff <= i_writedata[2:0];
            off_ff <= ctrl_ff[`SPU_CTL_CONTINUOUS_RECEIVE_ENABLE] ? 3'h0 : (off_ff == 3'h7 ? off_ff : off_ff + 3'h1);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Bus access steps
    sequence s_taken;
        (i_read || i_write) && o_waitrequest;
    endsequence
    sequence s_answer;
        !o_waitrequest ##1 o_waitrequest;
    endsequence
    a_one_wait_state: assert property (s_taken |=> s_answer)
        else $error("access not answered after one wait");
    a_wait_has_cause: assert property ($fell(o_waitrequest) |-> $past(i_read || i_write))
        else $error("answer without request");
    a_unmapped_zero: assert property (i_read && !o_waitrequest && i_address[1:0] != 2'h0
        |-> o_readdata == 32'h0) else $error("unmapped read not zero");
    a_upper_bits_zero: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_ninth_when_off: assert property (st_rd && !ctrl_ff[`SPU_CTL_RX9] |-> !o_readdata[0])
        else $error("ninth bit seen in eight bit mode");
    a_ninth_forced: assert property (st_rd && ctrl_ff[3] && ctrl_ff[4] |-> o_readdata[0])
        else $error("ninth bit not one under address detect");
    a_overrun_cleared: assert property (st_rd && off_ff == 3'h7 |-> !o_readdata[2])
        else $error("overrun kept with reception off");
    a_irq_gated: assert property (o_irq |-> en_ff != 3'h0 || $past(en_ff) != 3'h0)
        else $error("interrupt with all enables clear");
endmodule // spu_rx_properties
bind spu_rx spu_rx_properties u_spu_rx_properties (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_rxd(i_rxd), .o_irq(o_irq));

//--- sim/spu_rx_line_drv.sv
`timescale 1ns/1ns
module spu_rx_line_drv (
    // Clock
    input wire i_mclk,
    // Serial line, idle high
    output reg o_line
);
    initial o_line = 1'b1;
    ////////////////////////////////////////////////////////////////////////////
    // One frame: start, data LSB first, given stop level, then idle
    task send(input [8:0] d, input integer nb, input stp, input integer cpb);
        integer i;
        begin
            @(posedge i_mclk);
            o_line <= 1'b0;
            repeat (cpb) @(posedge i_mclk);
            for (i = 0; i < nb; i = i + 1) begin
                o_line <= d[i];
                repeat (cpb) @(posedge i_mclk);
            end
            o_line <= stp;
            repeat (cpb) @(posedge i_mclk);
            o_line <= 1'b1;
            repeat (cpb) @(posedge i_mclk);
        end
    endtask
    // Short low glitch, then idle long enough for a false frame to finish
    task pulse(input integer lo, input integer idle);
        begin
            @(posedge i_mclk);
            o_line <= 1'b0;
            repeat (lo) @(posedge i_mclk);
            o_line <= 1'b1;
            repeat (idle) @(posedge i_mclk);
        end
    endtask
endmodule // spu_rx_line_drv

//--- sim/spu_rx_tb_top.sv
`timescale 1ns/1ns
`include "spu_rx_consts.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module spu_rx_tb_top;
    reg         i_mclk;
    reg         i_rst_n;
    reg  [4:0]  i_address;
    reg         i_read;
    reg         i_write;
    reg  [31:0] i_writedata;
    wire [31:0] o_readdata;
    wire        o_waitrequest;
    wire        i_rxd;
    wire        o_irq;
    reg  [31:0] rv;
    integer     err_count = 0;
    integer     checks = 0;
    integer     cycles = 0;
    integer     k;
    spu_rx u_spu_rx (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_rxd(i_rxd), .o_irq(o_irq));
    spu_rx_line_drv u_spu_rx_line_drv (.i_mclk(i_mclk), .o_line(i_rxd));
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Bus access held until waitrequest is sampled low
    task bus(input rd, input [4:0] a, input [31:0] wd);
        begin
            @(posedge i_mclk);
            i_address <= a;
            i_read <= rd;
            i_write <= !rd;
            i_writedata <= wd;
            @(posedge i_mclk);
            while (o_waitrequest !== 1'b0) @(posedge i_mclk);
            rv = o_readdata;
            i_read <= 1'b0;
            i_write <= 1'b0;
        end
    endtask
    task wr(input [4:0] a, input [31:0] d);
        bus(1'b0, a, d);
    endtask
    task rchk(input [4:0] a, input [31:0] e);
        begin
            bus(1'b1, a, 32'h0);
            `CHK($sformatf("reg %h", a), e, rv)
        end
    endtask
    task send(input [8:0] d, input integer nb, input stp, input integer cpb);
        u_spu_rx_line_drv.send(d, nb, stp, cpb);
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks, err_count);
            if (err_count == 0 && checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Hang guard
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count = err_count + 1;
            conclude;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        i_rst_n = 1'b0;
        i_address = 5'h00;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0;
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rchk(`SPU_OFS_CTRL, 32'h0);
        rchk(5'h02, 32'h0);
        wr(`SPU_OFS_INT_EN, 32'h1);
        // Port off, receive off, then synchronous select set
        for (k = 0; k < 3; k = k + 1) begin
            wr(`SPU_OFS_CTRL, k == 0 ? 32'h64 : (k == 1 ? 32'h61 : 32'h67));
            send(9'hA5, 8, 1'b1, 4);
            rchk(`SPU_OFS_RX_STAT, 32'h0);
        end
        // Four rates: 4 ticks at divisor 0, 16 ticks at divisor 1, 64 ticks with the
        // high byte ignored, and 4 ticks at the wide divisor 256
        for (k = 0; k < 4; k = k + 1) begin
            wr(`SPU_OFS_BAUD_HI, k > 1);
            wr(`SPU_OFS_BAUD_LO, k == 1);
            wr(`SPU_OFS_CTRL, k == 1 ? 32'h25 : (k == 2 ? 32'h05 : 32'h65));
            send(9'h5A + k, 8, 1'b1, k == 1 ? 32 : (k == 2 ? 64 : (k == 3 ? 1028 : 4)));
            `CHK("irq", 1'b1, o_irq)
            rchk(`SPU_OFS_INT_ST, 32'h1);
            rchk(`SPU_OFS_RX_STAT, 32'h8);
            rchk(`SPU_OFS_RX_DATA, 32'h5A + k);
            rchk(`SPU_OFS_RX_STAT, 32'h0);
            wr(`SPU_OFS_INT_CLR, 32'h7);
            repeat (3) @(posedge i_mclk);
            `CHK("irq", 1'b0, o_irq)
        end
        // A short glitch, a masked interrupt and a low stop bit
        wr(`SPU_OFS_BAUD_HI, 32'h0);
        wr(`SPU_OFS_BAUD_LO, 32'h0);
        wr(`SPU_OFS_CTRL, 32'h65);
        wr(`SPU_OFS_INT_EN, 32'h0);
        u_spu_rx_line_drv.pulse(1, 48);
        rchk(`SPU_OFS_RX_STAT, 32'h0);
        send(9'h3C, 8, 1'b0, 4);
        `CHK("irq", 1'b0, o_irq)
        rchk(`SPU_OFS_RX_STAT, 32'hA);
        rchk(`SPU_OFS_INT_ST, 32'h5);
        rchk(`SPU_OFS_RX_DATA, 32'h3C);
        wr(`SPU_OFS_INT_CLR, 32'h7);
        // Third character overflows the two-entry buffer
        for (k = 1; k < 4; k = k + 1)
            send(9'h11 * k, 8, 1'b1, 4);
        rchk(`SPU_OFS_RX_STAT, 32'hC);
        rchk(`SPU_OFS_INT_ST, 32'h3);
        rchk(`SPU_OFS_RX_DATA, 32'h11);
        send(9'h44, 8, 1'b1, 4);
        rchk(`SPU_OFS_RX_DATA, 32'h22);
        rchk(`SPU_OFS_RX_STAT, 32'h4);
        wr(`SPU_OFS_CTRL, 32'h61);
        repeat (8) @(posedge i_mclk);
        rchk(`SPU_OFS_RX_STAT, 32'h0);
        // Address detect drops a ninth bit of zero, then lets all in
        wr(`SPU_OFS_CTRL, 32'h7D);
        send(9'h055, 9, 1'b1, 4);
        send(9'h1AA, 9, 1'b1, 4);
        rchk(`SPU_OFS_RX_STAT, 32'h9);
        rchk(`SPU_OFS_RX_DATA, 32'hAA);
        wr(`SPU_OFS_CTRL, 32'h6D);
        send(9'h0C3, 9, 1'b1, 4);
        send(9'h1E7, 9, 1'b1, 4);
        rchk(`SPU_OFS_RX_STAT, 32'h8);
        rchk(`SPU_OFS_RX_DATA, 32'hC3);
        rchk(`SPU_OFS_RX_STAT, 32'h9);
        rchk(`SPU_OFS_RX_DATA, 32'hE7);
        // Reset in mid-run returns registers and events to zero
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rchk(`SPU_OFS_INT_ST, 32'h0);
        rchk(`SPU_OFS_CTRL, 32'h0);
        conclude;
    end
endmodule // spu_rx_tb_top
